//--- logic/pnsr_pkg.sv
// shared constants and types for the pseudo-noise sequence generator
package pnsr_pkg;

  // default feedback taps, binary 10000100
  localparam logic [7:0] DEF_TAPS = 8'h84;
  // default seed word, binary 10101010
  localparam logic [7:0] DEF_SEED = 8'haa;

  // register width limit and packing defaults
  localparam int MAX_LEN = 32;
  localparam int WORD_W = 8;
  localparam int FIFO_DEPTH = 16;

  // synchroniser depth for the clock pin
  localparam int SYNC_STAGES = 2;

  // clock period of clk_sys in nanoseconds
  localparam int CLK_PERIOD_NS = 50;

  typedef enum logic [1:0] {
    ST_LOAD = 2'b00,
    ST_RUN = 2'b01,
    ST_STUCK = 2'b10
  } pnsr_state_type;

endpackage : pnsr_pkg

//--- logic/pnsr_sync.sv
// two flip-flop synchroniser for an asynchronous level
`timescale 1ns/100ps

module pnsr_sync #(
  parameter int STAGES = pnsr_pkg::SYNC_STAGES
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic asyncIn,
  output logic syncOut
);

  logic [STAGES-1:0] chain;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      chain <= '0;
    end
    else if (clkEn)
    begin
      chain <= {chain[STAGES-2:0], asyncIn};
    end
  end

  assign syncOut = chain[STAGES-1];

endmodule : pnsr_sync

//--- logic/pnsr_fifo.sv
// flip-flop fifo with valid and ready on both sides
`timescale 1ns/100ps

module pnsr_fifo #(
  parameter int WIDTH = pnsr_pkg::WORD_W,
  parameter int DEPTH = pnsr_pkg::FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr;
  logic [AW:0] rdPtr;

  wire logic isEmpty = (wrPtr == rdPtr);
  wire logic isFull = (wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
  wire logic doWrite = inValid && !isFull && clkEn;
  wire logic doRead = outReady && !isEmpty && clkEn;

  assign inReady = !isFull;
  assign outValid = !isEmpty;
  assign outData = mem[rdPtr[AW-1:0]];

  always_ff @(posedge clk_sys)
  begin
    if (doWrite)
    begin
      mem[wrPtr[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
    end
    else
    begin
      if (doWrite)
      begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (doRead)
      begin
        rdPtr <= rdPtr + 1'b1;
      end
    end
  end

endmodule : pnsr_fifo

//--- logic/pnsr_clocked_pn_shift_register.sv
// pseudo-noise bit generator clocked by an external clock pin
`timescale 1ns/100ps

// How it works
// R1: one new bit per rising edge of the clock pin; state held otherwise.
// R2: an edge is a low-to-high change of the synchronised clock pin.
// R3: history shifts one place older each edge; new bit enters newest place.
// R4: register length is the position, from one, of the highest tap bit.
// R5: new bit is the xor of history bits selected by the taps.
// R6: tap bit k-1 selects the bit produced k steps earlier.
// R7: seed bit k-1 gives history value k steps before the first edge.
// R8: taps default to binary 10000100 when the user sets none.
// R9: seed defaults to binary 10101010 when the user sets none.
// R10: user picks maximal-length taps so the period is two to r minus one.
// R11: restart reloads history from the seed and begins again.
// R12: output bit shows the latest computed bit until the next edge; a restart clears it to zero.
module pnsr_clocked_pn_shift_register #(
  parameter int MAX_LEN = pnsr_pkg::MAX_LEN,
  parameter int WORD_W = pnsr_pkg::WORD_W,
  parameter int FIFO_DEPTH = pnsr_pkg::FIFO_DEPTH,
  parameter logic [MAX_LEN-1:0] DEF_TAPS = MAX_LEN'(pnsr_pkg::DEF_TAPS),
  parameter logic [MAX_LEN-1:0] DEF_SEED = MAX_LEN'(pnsr_pkg::DEF_SEED)
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic pnClkPin,
  input wire logic restart,
  input wire logic tapsValid,
  input wire logic [MAX_LEN-1:0] tapMask,
  input wire logic seedValid,
  input wire logic [MAX_LEN-1:0] seedWord,
  output logic pnBit,
  output logic bitStrobe,
  output logic [$clog2(MAX_LEN+1)-1:0] regLength,
  output logic running,
  output logic stuck,
  output logic periodFound,
  output logic [MAX_LEN-1:0] periodCount,
  output logic overrun,
  output logic packReady,
  output logic [WORD_W-1:0] wordData,
  output logic wordValid,
  input wire logic wordReady
);

  localparam int LEN_W = $clog2(MAX_LEN+1);
  localparam int PACK_W = $clog2(WORD_W);
  localparam logic [PACK_W-1:0] PACK_LAST = PACK_W'(WORD_W-1);

  // position of the highest set bit, counted from one
  function automatic logic [LEN_W-1:0] top_bit(input logic [MAX_LEN-1:0] m);
    logic [LEN_W-1:0] r;
    r = '0;
    for (int i = 0; i < MAX_LEN; i++)
    begin
      if (m[i])
      begin
        r = LEN_W'(i + 1);
      end
    end
    return r;
  endfunction : top_bit

  // ones in the lowest len places
  function automatic logic [MAX_LEN-1:0] low_mask(input logic [LEN_W-1:0] len);
    logic [MAX_LEN-1:0] mk;
    mk = '0;
    for (int i = 0; i < MAX_LEN; i++)
    begin
      if (i < int'(len))
      begin
        mk[i] = 1'b1;
      end
    end
    return mk;
  endfunction : low_mask

  pnsr_pkg::pnsr_state_type state;
  pnsr_pkg::pnsr_state_type next_state;

  logic clkSync;
  logic clkPrev;
  logic loadPending;
  logic [MAX_LEN-1:0] activeTaps;
  logic [MAX_LEN-1:0] hist;
  logic [MAX_LEN-1:0] startHist;
  logic [MAX_LEN-1:0] lenMask;
  logic [MAX_LEN-1:0] bitCount;
  logic [WORD_W-1:0] packWord;
  logic [PACK_W-1:0] packIdx;
  logic fifoInReady;

  pnsr_sync #(
    .STAGES(pnsr_pkg::SYNC_STAGES)
  ) u_clk_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .clkEn(clkEn),
    .asyncIn(pnClkPin),
    .syncOut(clkSync)
  );

  // user setting or default
  wire logic [MAX_LEN-1:0] selTaps = tapsValid ? tapMask : DEF_TAPS; // R8
  wire logic [MAX_LEN-1:0] selSeed = seedValid ? seedWord : DEF_SEED; // R9
  wire logic [LEN_W-1:0] selLen = top_bit(selTaps); // R4
  wire logic [MAX_LEN-1:0] selMask = low_mask(selLen);
  wire logic [MAX_LEN-1:0] loadHist = selSeed & selMask; // R7

  wire logic risingEdge = clkSync && !clkPrev; // R2
  wire logic doLoad = loadPending || restart; // R11
  wire logic doStep = risingEdge && !doLoad && (state != pnsr_pkg::ST_LOAD); // R1

  // hist[k-1] holds the bit produced k steps earlier
  wire logic feedback = ^(hist & activeTaps); // R5 R6
  wire logic [MAX_LEN-1:0] nextHist = {hist[MAX_LEN-2:0], feedback} & lenMask; // R3
  wire logic returnedHome = (nextHist == startHist);
  wire logic pushNow = doStep && (packIdx == PACK_LAST);
  wire logic [WORD_W-1:0] pushWord = {packWord[WORD_W-2:0], feedback};
  wire logic lostWord = pushNow && !fifoInReady;

  always_comb
  begin
    next_state = state;
    case (state)
      pnsr_pkg::ST_LOAD:
      begin
        next_state = pnsr_pkg::ST_LOAD;
      end
      pnsr_pkg::ST_RUN:
      begin
        next_state = pnsr_pkg::ST_RUN;
      end
      pnsr_pkg::ST_STUCK:
      begin
        next_state = pnsr_pkg::ST_STUCK;
      end
      default:
      begin
        next_state = pnsr_pkg::ST_LOAD;
      end
    endcase
    if (doLoad)
    begin
      // an all-zero history only ever repeats zero
      next_state = (loadHist == '0) ? pnsr_pkg::ST_STUCK : pnsr_pkg::ST_RUN;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= pnsr_pkg::ST_LOAD;
      loadPending <= 1'b1;
      clkPrev <= 1'b0;
    end
    else if (clkEn)
    begin
      state <= next_state;
      loadPending <= 1'b0;
      clkPrev <= clkSync;
    end
  end

  // taps and length are captured at load so the history stays consistent
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      activeTaps <= '0;
      lenMask <= '0;
      regLength <= '0;
      startHist <= '0;
    end
    else if (clkEn && doLoad)
    begin
      activeTaps <= selTaps;
      lenMask <= selMask;
      regLength <= selLen; // R4
      startHist <= loadHist;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      hist <= '0;
      pnBit <= 1'b0;
      bitStrobe <= 1'b0;
    end
    else if (clkEn)
    begin
      bitStrobe <= doStep;
      if (doLoad)
      begin
        hist <= loadHist; // R7 R11
        pnBit <= 1'b0;
      end
      else if (doStep)
      begin
        hist <= nextHist; // R3
        pnBit <= feedback; // R12
      end
    end
  end

  // period measurement: bits until the history first returns to its seed
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      bitCount <= '0;
      periodFound <= 1'b0;
      periodCount <= '0;
    end
    else if (clkEn)
    begin
      if (doLoad)
      begin
        bitCount <= '0;
        periodFound <= 1'b0;
        periodCount <= '0;
      end
      else if (doStep)
      begin
        bitCount <= bitCount + 1'b1;
        if (returnedHome && !periodFound)
        begin
          periodFound <= 1'b1; // R10
          periodCount <= bitCount + 1'b1;
        end
      end
    end
  end

  // packing of bits into words, newest bit in the lsb
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      packWord <= '0;
      packIdx <= '0;
    end
    else if (clkEn)
    begin
      if (doLoad)
      begin
        packWord <= '0;
        packIdx <= '0;
      end
      else if (doStep)
      begin
        packWord <= pushWord;
        packIdx <= pushNow ? '0 : packIdx + 1'b1;
      end
    end
  end

  // lost word flag; a restart clears it, and no loss can occur in a restart cycle
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      overrun <= 1'b0;
    end
    else if (clkEn)
    begin
      if (lostWord)
      begin
        overrun <= 1'b1;
      end
      else if (restart)
      begin
        overrun <= 1'b0;
      end
    end
  end

  pnsr_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_word_fifo (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .clkEn(clkEn),
    .inValid(pushNow),
    .inReady(fifoInReady),
    .inData(pushWord),
    .outValid(wordValid),
    .outReady(wordReady),
    .outData(wordData)
  );

  assign packReady = fifoInReady;
  assign running = (state == pnsr_pkg::ST_RUN);
  assign stuck = (state == pnsr_pkg::ST_STUCK);

endmodule : pnsr_clocked_pn_shift_register

//--- tb/pnsr_sva.sv
// assertions on the ports of the sequence generator
`timescale 1ns/100ps

module pnsr_sva (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic pnClkPin,
  input wire logic restart,
  input wire logic tapsValid,
  input wire logic pnBit,
  input wire logic bitStrobe,
  input wire logic [5:0] regLength,
  input wire logic running,
  input wire logic stuck,
  input wire logic periodFound,
  input wire logic packReady,
  input wire logic [7:0] wordData,
  input wire logic wordValid,
  input wire logic wordReady
);
  default clocking cb @(posedge clk_sys);
  endclocking
  // a frozen cycle is no cycle at all for the design
  default disable iff (!nrst || !clkEn);

  sequence pinRise;
    !pnClkPin ##1 pnClkPin;
  endsequence
  sequence quietRun;
    (running && !restart) [*3];
  endsequence

  edge_makes_step_a: assert property (pinRise ##0 quietRun |-> ##[0:1] bitStrobe) else $error("no step");
  strobe_single_a: assert property (bitStrobe |=> !bitStrobe) else $error("strobe too long");
  strobe_cause_a: assert property (bitStrobe |-> $past(pnClkPin, 2)) else $error("step without pin");
  bit_hold_a: assert property (!bitStrobe && !$past(restart) |-> $stable(pnBit)) else $error("bit moved");
  load_clear_a: assert property (restart |=> !pnBit && !bitStrobe && !periodFound) else $error("load");
  default_length_a: assert property (restart && !tapsValid |=> regLength == 6'h08) else $error("len");
  step_running_a: assert property (bitStrobe |-> running || stuck) else $error("step while idle");
  stuck_zero_a: assert property (stuck && bitStrobe |-> !pnBit) else $error("stuck made a one");
  run_or_stuck_a: assert property (!(running && stuck)) else $error("both flags");
  word_hold_a: assert property (wordValid && !wordReady |=> wordValid && $stable(wordData)) else $error("word");
  full_has_word_a: assert property (!packReady |-> wordValid) else $error("full but empty");
endmodule : pnsr_sva

//--- tb/pnsr_partner.sv
// clock source and word consumer facing the generator
`timescale 1ns/100ps

module pnsr_partner (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic go,
  input wire logic stall,
  output logic pinOut,
  output logic takeWord
);
  logic [2:0] phase;

  // a started pulse always completes; pin rests low between pulses
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      phase <= 3'h0;
    else if (go || phase != 3'h0)
      phase <= (phase == 3'h5) ? 3'h0 : phase + 3'h1;
  end
  assign pinOut = (phase >= 3'h1) && (phase <= 3'h3);
  assign takeWord = !stall;
endmodule : pnsr_partner

//--- tb/pnsr_clocked_pn_shift_register_tb_top.sv
// self-checking bench for the sequence generator
`timescale 1ns/100ps

module pnsr_clocked_pn_shift_register_tb_top;
  typedef struct packed {logic tv; logic [31:0] t; logic sv; logic [31:0] s; logic [5:0] len;} pnsr_row_type;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic restart = 1'b0;
  logic tapsValid = 1'b0;
  logic seedValid = 1'b0;
  logic [31:0] tapMask = 32'h0;
  logic [31:0] seedWord = 32'h0;
  logic go = 1'b0;
  logic stall = 1'b1;
  logic clkEn = 1'b1;
  int nBits = 0;
  logic pnClkPin, wordReady, pnBit, bitStrobe, running, stuck, periodFound, overrun, packReady, wordValid;
  logic [5:0] regLength;
  logic [31:0] periodCount, hist, taps, mask;
  logic [7:0] wordData, acc;
  logic [7:0] expWords[$];
  int bad_count = 0;
  int n_compared = 0;
  // taps valid, taps, seed valid, seed, length
  pnsr_row_type rows[4] = '{
    '{1'b0, 32'h0, 1'b0, 32'h0, 6'h08},
    '{1'b1, 32'h47, 1'b1, 32'h2, 6'h07},
    '{1'b1, 32'h3, 1'b1, 32'h1, 6'h02},
    '{1'b1, 32'h80200003, 1'b1, 32'hffffffff, 6'h20}};

  always #25 clk_sys = ~clk_sys;

  pnsr_clocked_pn_shift_register i_pnsr_clocked_pn_shift_register (
    .clk_sys, .nrst, .clkEn, .pnClkPin, .restart, .tapsValid, .tapMask, .seedValid, .seedWord, .pnBit,
    .bitStrobe, .regLength, .running, .stuck, .periodFound, .periodCount, .overrun, .packReady, .wordData,
    .wordValid, .wordReady);
  pnsr_partner i_pnsr_partner (.clk_sys, .nrst, .go, .stall, .pinOut(pnClkPin), .takeWord(wordReady));

  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic wait_high(input bit forWord);
    int g;
    for (g = 0; g < 40 && (forWord ? wordValid : bitStrobe) !== 1'b1; g++)
      tick();
    if (g == 40)
    begin
      bad_count++;
      wrap_up();
    end
  endtask : wait_high

  task automatic load(input pnsr_row_type w);
    int r;
    tapsValid = w.tv;
    tapMask = w.t;
    seedValid = w.sv;
    seedWord = w.s;
    restart = 1'b1;
    taps = w.tv ? w.t : 32'h84;
    r = 0;
    for (int k = 0; k < 32; k++)
      if (taps[k])
        r = k + 1;
    mask = 32'((64'h1 << r) - 64'h1);
    hist = (w.sv ? w.s : 32'haa) & mask;
    expWords.delete();
    nBits = 0;
    tick();
    restart = 1'b0;
    chk(regLength, w.len);
    chk(running, 32'(hist != 0));
    chk(stuck, 32'(hist == 0));
  endtask : load

  task automatic steps(input int n);
    logic nb;
    tick();
    go = 1'b1;
    for (int i = 0; i < n; i++)
    begin
      tick();
      wait_high(1'b0);
      nb = ^(hist & taps);
      hist = ((hist << 1) | 32'(nb)) & mask;
      chk(pnBit, nb);
      acc = {acc[6:0], nb};
      nBits++;
      // words are counted from the load, across calls
      if (nBits % 8 == 0)
        expWords.push_back(acc);
    end
    go = 1'b0;
  endtask : steps

  task automatic drain();
    stall = 1'b0;
    foreach (expWords[i])
    begin
      wait_high(1'b1);
      chk(wordData, expWords[i]);
      tick();
    end
    stall = 1'b1;
    chk(wordValid, 1'b0);
  endtask : drain

  initial
  begin
    repeat (4) @(posedge clk_sys);
    #1;
    chk(pnBit, 1'b0);
    chk(packReady, 1'b1);
    nrst = 1'b1;
    tick();
    chk(regLength, 6'h08);
    $display("reset test done");
    foreach (rows[i])
    begin
      load(rows[i]);
      steps(16);
      drain();
      $display("row %0d done", i);
    end
    tick();
    clkEn = 1'b0;
    restart = 1'b1;
    tapsValid = 1'b0;
    repeat (3) tick();
    chk(regLength, rows[3].len);
    chk(pnBit, 32'(hist[0]));
    restart = 1'b0;
    tick();
    clkEn = 1'b1;
    tick();
    chk(regLength, rows[3].len);
    chk(pnBit, 32'(hist[0]));
    chk(bitStrobe, 1'b0);
    $display("freeze test done");
    load(rows[1]);
    steps(127);
    chk(periodFound, 1'b1);
    chk(periodCount, 32'h7f);
    steps(9);
    chk(packReady, 1'b0);
    chk(overrun, 1'b1);
    void'(expWords.pop_back());
    drain();
    $display("period and overrun test done");
    load(rows[0]);
    chk(overrun, 1'b0);
    $display("restart test done");
    load('{1'b1, 32'h47, 1'b1, 32'h0, 6'h07});
    steps(2);
    $display("stuck test done");
    wrap_up();
  end
endmodule : pnsr_clocked_pn_shift_register_tb_top

bind pnsr_clocked_pn_shift_register pnsr_sva i_pnsr_sva (.clk_sys, .nrst, .clkEn, .pnClkPin, .restart, .tapsValid, .pnBit,
  .bitStrobe, .regLength, .running, .stuck, .periodFound, .packReady, .wordData, .wordValid, .wordReady);
